// ### design/dicr_pkg.sv
// package of the digital input conditioning and routing block
// assumes: used by dicr_route_mem and dicr_input_router as dicr_pkg::name, nothing imported
package dicr_pkg;

  // ==========================================================
  // geometry
  localparam int unsigned NUM_INPUTS = 6;
  localparam int unsigned NUM_AUX = 4;
  localparam int unsigned ROUTE_ENTRIES = 32;
  localparam int unsigned CODE_W = 8;
  localparam int unsigned LEVEL_BASE = 16;

  // ==========================================================
  // timing: 1 ms sample period on a 40 MHz pclk
  localparam int unsigned CLK_FREQ_HZ = 40_000_000;
  localparam int unsigned SAMPLE_PERIOD_US = 1000;
  localparam int unsigned SAMPLE_CYCLES =
    (CLK_FREQ_HZ / 1_000_000) * SAMPLE_PERIOD_US;

  // ==========================================================
  // register byte offsets on the apb slave
  localparam logic [11:0] OFF_SFE = 12'h000;
  localparam logic [11:0] OFF_INV = 12'h004;
  localparam logic [11:0] OFF_FORCE_EN = 12'h008;
  localparam logic [11:0] OFF_FORCE_VAL = 12'h00C;
  localparam logic [11:0] OFF_RAW = 12'h010;
  localparam logic [11:0] OFF_THRESH = 12'h014;
  localparam logic [11:0] OFF_DIFF = 12'h018;
  localparam logic [11:0] OFF_ROUTE_EN = 12'h01C;
  localparam logic [11:0] OFF_SUMMARY = 12'h020;
  localparam logic [11:0] OFF_TABLE = 12'h080;
  localparam logic [4:0] TABLE_PAGE = 5'h01;

  // ==========================================================
  // field positions and reset values
  localparam int unsigned SFE_NEG_LIMIT = 0;
  localparam int unsigned SFE_POS_LIMIT = 1;
  localparam int unsigned SFE_HOME = 2;
  localparam int unsigned SFE_INTERLOCK = 3;
  localparam int unsigned IN_DIR = 1;
  localparam int unsigned IN_CLK = 2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ==========================================================
  // route source codes
  localparam logic [7:0] SRC_INVERT = 8'h80;
  localparam logic [6:0] SRC_PHYS_LAST = 7'h10;
  localparam logic [6:0] SRC_ENC_A = 7'h44;
  localparam logic [6:0] SRC_USB = 7'h47;

  // apb read sequencing
  typedef enum logic [1:0] {
    RD_ISSUE = 2'b00,
    RD_CAPTURE = 2'b01,
    RD_DONE = 2'b10
  } dicr_rd_t;

endpackage

// ### design/dicr_mem_if.sv
// single-port carrier between the router and its route table memory
// assumes: one owner drives the port at a time, inside pclk domain
`timescale 1ns/1ps
interface dicr_mem_if;
  logic we;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

// ### design/dicr_route_mem.sv
// route source table: 32 entries of 8 bits, registered read data
// assumes: pclk domain, one access per cycle through dicr_mem_if
`timescale 1ns/1ps
module dicr_route_mem #(
  parameter int unsigned DEPTH = dicr_pkg::ROUTE_ENTRIES,
  parameter int unsigned WIDTH = dicr_pkg::CODE_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // table port
  dicr_mem_if.mem port
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  // ==========================================================
  // storage, cleared to constant 0 on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (port.we) begin
      mem_r[port.addr] <= port.wdata;
    end
  end

  // read data always from a register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port.rdata <= '0;
    end else begin
      port.rdata <= mem_r[port.addr];
    end
  end

endmodule

// ### design/dicr_input_router.sv
// digital input conditioning and routing block with apb registers
// assumes: pclk 40 MHz, async active-low presetn, pins are asynchronous
//
// Notes on behaviour
// - inputs sampled once per millisecond; shorter level changes are not seen
// - threshold bit n-1 picks 5 V (0) or 24 V (1) for input n
// - one differential select: 0 six single-ended, 1 three differential
// - input 1 neg limit, 2 pos limit/dir, 3 home/clock, 4-6 none
// - special enable bits: 0 neg limit, 1 pos limit, 2 home, 3 interlock
// - special enables never touch summary bits 16 to 31
// - polarity bit n-1: 0 high reads 1, 1 high reads 0
// - inversion covers specials too, but not clock-direction clock and dir
// - force enable bit replaces sampled level with force value bit
// - raw field always shows sampled levels, no force or inversion
// - input 1 gives neg limit result at bit 0, full level at bit 16
// - routing enable 1 takes every summary bit from a chosen source
// - while routing, enable, polarity and force settings have no effect; enable bits still gate the limit, home and interlock outputs
// - enabling routing preloads table to keep prior behaviour, except force and clkdir_mode polarity on bits 17, 18
// - table entry k feeds summary bit k
// - code 00 is 0, 01-10 physical inputs, 44-47 encoder and usb power; only 01-06 are decoded, 07-10 give 0
// - code bit 7 inverts the source; 80 is constant 1
// - interlock enabled and bit 3 low means fault; high permits motion
// - interlock acts only with enable bit 3; its source is routed
// - bits 16 up show plain level of input n at bit 15+n
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module dicr_input_router #(
  parameter int unsigned SAMPLE_CYCLES = dicr_pkg::SAMPLE_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // input pins and auxiliary sources
  input wire logic [5:0] in_pin,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_index,
  input wire logic usb_power,
  // motion context
  input wire logic clkdir_mode,
  // analog front end control
  output logic [5:0] thresh_24v,
  output logic diff_mode,
  // results
  output logic [31:0] input_summary_word,
  output logic limit_neg,
  output logic limit_pos,
  output logic home_switch,
  output logic interlock_fault,
  output logic route_active
);

  localparam int unsigned NIN = dicr_pkg::NUM_INPUTS;
  localparam int unsigned NSYNC = NIN + dicr_pkg::NUM_AUX;
  localparam int unsigned TW = $clog2(SAMPLE_CYCLES);

  // ==========================================================
  // registers
  logic [3:0] sfe_r;
  logic [5:0] inv_r;
  logic [5:0] force_en_r;
  logic [5:0] force_val_r;
  logic [5:0] raw_r;
  logic [5:0] thresh_r;
  logic diff_r;
  logic route_en_r;
  logic [31:0] summary_r;
  logic [31:0] route_bits_r;
  logic [TW-1:0] tick_cnt_r;
  logic tick;
  logic [NSYNC-1:0] s1_r, s2_r, s3_r, flt_r;
  logic preload_r;
  logic [4:0] pre_idx_r;
  logic scan_r;
  logic [4:0] scan_idx_r;
  logic rd_tag_r;
  logic [4:0] rd_idx_r;
  dicr_pkg::dicr_rd_t rd_st_r;
  logic [31:0] prdata_r;
  logic err_r;

  dicr_mem_if mport ();

  dicr_route_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .port(mport)
  );

  // ==========================================================
  // functions
  // table page decode, used for access and error checks
  function automatic logic is_tbl(input logic [11:0] a);
    return a[11:7] == dicr_pkg::TABLE_PAGE && a[1:0] == 2'b00;
  endfunction

  // route source value from a code
  function automatic logic src_val(input logic [7:0] code,
                                  input logic [5:0] raw,
                                  input logic [3:0] aux);
    logic v;
    logic [6:0] b;
    v = 1'b0;
    b = code[6:0];
    if (b >= 7'h01 && b <= 7'h06) begin
      v = raw[3'(b - 7'h01)];
    end else if (b >= dicr_pkg::SRC_ENC_A && b <= dicr_pkg::SRC_USB) begin
      v = aux[2'(b - dicr_pkg::SRC_ENC_A)];
    end
    return v ^ code[7];
  endfunction

  // preload code that reproduces normal-mode behaviour except force and the clock-direction polarity on bits 17 and 18
  function automatic logic [7:0] pre_code(input logic [4:0] k,
                                          input logic [3:0] sfe,
                                          input logic [5:0] inv,
                                          input logic cd);
    logic [7:0] c;
    logic [4:0] n;
    c = 8'h00;
    n = 5'(k - 5'(dicr_pkg::LEVEL_BASE));
    if (k >= 5'(dicr_pkg::LEVEL_BASE) && n < 5'(NIN)) begin
      c = {inv[n[2:0]], 4'h0, 3'(n + 5'd1)};
    end else if (k < 5'd3 && sfe[k[1:0]]) begin
      c = {inv[k[2:0]] & ~(cd && k != 5'd0), 4'h0, 3'(k + 5'd1)};
    end
    return c;
  endfunction

  // ==========================================================
  // apb decode
  logic access, tbl, mapped, ro_hit, port_free;
  logic wr_go, rd_go;

  assign access = psel & penable;
  assign tbl = is_tbl(paddr);
  assign ro_hit = paddr == dicr_pkg::OFF_RAW ||
                  paddr == dicr_pkg::OFF_SUMMARY;
  assign mapped = tbl || (paddr[11:6] == 6'h00 && paddr[1:0] == 2'b00 &&
                  paddr <= dicr_pkg::OFF_SUMMARY);
  assign port_free = ~preload_r;
  assign pready = pwrite ? ~(tbl & preload_r) : rd_st_r == dicr_pkg::RD_DONE;
  assign wr_go = access & pwrite & pready & mapped & ~ro_hit;
  assign rd_go = access & ~pwrite & rd_st_r == dicr_pkg::RD_ISSUE &&
                 (~tbl | port_free);
  assign pslverr = access & pready & (~mapped | (pwrite & ro_hit));
  assign prdata = prdata_r;

  // ==========================================================
  // 1 ms sample tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end
  assign tick = tick_cnt_r == TW'(SAMPLE_CYCLES - 1);

  // three-stage synchronisers, change taken once stages 2 and 3 agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      flt_r <= '0;
    end else begin
      s1_r <= {usb_power, enc_index, enc_b, enc_a, in_pin};
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < NSYNC; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          flt_r[i] <= s3_r[i];
        end
      end
    end
  end

  // raw sample per tick; differential pairs compare plus against minus
  logic [5:0] pin_lvl;
  always_comb begin
    pin_lvl = flt_r[NIN-1:0];
    if (diff_r) begin
      pin_lvl = '0;
      for (int k = 0; k < NIN / 2; k++) begin
        pin_lvl[k] = flt_r[2*k+1] & ~flt_r[2*k];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_r <= '0;
    end else if (tick) begin
      raw_r <= pin_lvl;
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sfe_r <= '0;
      inv_r <= '0;
      force_en_r <= '0;
      force_val_r <= '0;
      thresh_r <= '0;
      diff_r <= 1'b0;
      route_en_r <= 1'b0;
    end else if (wr_go && !tbl) begin
      unique case (paddr)
        dicr_pkg::OFF_SFE: sfe_r <= pwdata[3:0];
        dicr_pkg::OFF_INV: inv_r <= pwdata[5:0];
        dicr_pkg::OFF_FORCE_EN: force_en_r <= pwdata[5:0];
        dicr_pkg::OFF_FORCE_VAL: force_val_r <= pwdata[5:0];
        dicr_pkg::OFF_THRESH: thresh_r <= pwdata[5:0];
        dicr_pkg::OFF_DIFF: diff_r <= pwdata[0];
        dicr_pkg::OFF_ROUTE_EN: route_en_r <= pwdata[0];
        default: ;
      endcase
    end
  end

  assign thresh_24v = thresh_r;
  assign diff_mode = diff_r;

  // ==========================================================
  // preload walk on enabling routing
  logic route_rise;
  assign route_rise = wr_go && !tbl && paddr == dicr_pkg::OFF_ROUTE_EN &&
                      pwdata[0] && !route_en_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preload_r <= 1'b0;
      pre_idx_r <= '0;
    end else if (route_rise) begin
      preload_r <= 1'b1;
      pre_idx_r <= '0;
    end else if (preload_r) begin
      pre_idx_r <= pre_idx_r + 1'b1;
      preload_r <= pre_idx_r != 5'h1F;
    end
  end

  // routing counts as active only once the table is preloaded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_active <= 1'b0;
    end else begin
      route_active <= route_en_r & ~preload_r & ~route_rise;
    end
  end

  // ==========================================================
  // table scan, one pass per tick, yields to preload and apb
  logic apb_port, scan_go;
  assign apb_port = (wr_go | rd_go) & tbl;
  assign scan_go = scan_r & ~preload_r & ~apb_port;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_r <= 1'b0;
      scan_idx_r <= '0;
    end else if (tick) begin
      scan_r <= 1'b1;
      scan_idx_r <= '0;
    end else if (scan_go) begin
      scan_idx_r <= scan_idx_r + 1'b1;
      scan_r <= scan_idx_r != 5'h1F;
    end
  end

  // port ownership: preload, then apb, then scan
  always_comb begin
    mport.we = 1'b0;
    mport.addr = scan_idx_r;
    mport.wdata = '0;
    if (preload_r) begin
      mport.we = 1'b1;
      mport.addr = pre_idx_r;
      mport.wdata = pre_code(pre_idx_r, sfe_r, inv_r, clkdir_mode);
    end else if (apb_port) begin
      mport.we = wr_go;
      mport.addr = paddr[6:2];
      mport.wdata = pwdata[7:0];
    end
  end

  // scan results land one cycle after issue
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_tag_r <= 1'b0;
      rd_idx_r <= '0;
      route_bits_r <= '0;
    end else begin
      rd_tag_r <= scan_go;
      rd_idx_r <= scan_idx_r;
      if (rd_tag_r) begin
        route_bits_r[rd_idx_r] <= src_val(mport.rdata, raw_r,
                                          flt_r[NSYNC-1:NIN]);
      end
    end
  end

  // ==========================================================
  // normal-mode computation: sample, force, then polarity
  logic [5:0] lvl;
  logic [5:0] inv_eff;
  logic [31:0] norm_word;
  always_comb begin
    inv_eff = inv_r;
    if (clkdir_mode) begin
      inv_eff[dicr_pkg::IN_DIR] = 1'b0;
      inv_eff[dicr_pkg::IN_CLK] = 1'b0;
    end
    lvl = ((raw_r & ~force_en_r) | (force_val_r & force_en_r)) ^ inv_eff;
    norm_word = '0;
    norm_word[dicr_pkg::LEVEL_BASE +: NIN] = lvl;
    for (int i = 0; i < 3; i++) begin
      norm_word[i] = sfe_r[i] & lvl[i];
    end
  end

  // summary word; routing overrides every bit while active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      summary_r <= dicr_pkg::RST_WORD;
    end else begin
      summary_r <= route_active ? route_bits_r : norm_word;
    end
  end
  assign input_summary_word = summary_r;

  // special-function outputs and interlock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_neg <= 1'b0;
      limit_pos <= 1'b0;
      home_switch <= 1'b0;
      interlock_fault <= 1'b0;
    end else begin
      limit_neg <= sfe_r[dicr_pkg::SFE_NEG_LIMIT] &
                   summary_r[dicr_pkg::SFE_NEG_LIMIT];
      limit_pos <= sfe_r[dicr_pkg::SFE_POS_LIMIT] & ~clkdir_mode &
                   summary_r[dicr_pkg::SFE_POS_LIMIT];
      home_switch <= sfe_r[dicr_pkg::SFE_HOME] & ~clkdir_mode &
                     summary_r[dicr_pkg::SFE_HOME];
      interlock_fault <= sfe_r[dicr_pkg::SFE_INTERLOCK] &
                         ~summary_r[dicr_pkg::SFE_INTERLOCK];
    end
  end

  // ==========================================================
  // apb read: issue, capture, complete
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_st_r <= dicr_pkg::RD_ISSUE;
      prdata_r <= '0;
      err_r <= 1'b0;
    end else begin
      unique case (rd_st_r)
        dicr_pkg::RD_ISSUE: begin
          if (rd_go) begin
            rd_st_r <= dicr_pkg::RD_CAPTURE;
            err_r <= tbl;
          end
        end
        dicr_pkg::RD_CAPTURE: begin
          rd_st_r <= dicr_pkg::RD_DONE;
          prdata_r <= '0;
          if (err_r) begin
            prdata_r <= {24'h00_0000, mport.rdata};
          end else if (mapped) begin
            unique case (paddr)
              dicr_pkg::OFF_SFE: prdata_r <= {28'h000_0000, sfe_r};
              dicr_pkg::OFF_INV: prdata_r <= {26'h000_0000, inv_r};
              dicr_pkg::OFF_FORCE_EN: prdata_r <= {26'h000_0000, force_en_r};
              dicr_pkg::OFF_FORCE_VAL: prdata_r <= {26'h000_0000, force_val_r};
              dicr_pkg::OFF_RAW: prdata_r <= {26'h000_0000, raw_r};
              dicr_pkg::OFF_THRESH: prdata_r <= {26'h000_0000, thresh_r};
              dicr_pkg::OFF_DIFF: prdata_r <= {31'h0000_0000, diff_r};
              dicr_pkg::OFF_ROUTE_EN: prdata_r <= {31'h0000_0000, route_en_r};
              dicr_pkg::OFF_SUMMARY: prdata_r <= summary_r;
              default: ;
            endcase
          end
        end
        dicr_pkg::RD_DONE: begin
          rd_st_r <= dicr_pkg::RD_ISSUE;
        end
        default: rd_st_r <= dicr_pkg::RD_ISSUE;
      endcase
    end
  end

endmodule

// ### verification/dicr_input_router_properties.sv
// checker: port-level relations of the input conditioning router
// assumes: bound to dicr_input_router, single pclk domain
`timescale 1ns/1ps
module dicr_input_router_props #(
  parameter int unsigned SAMPLE_CYCLES = 20
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // context and results
  input wire logic clkdir_mode,
  input wire logic [5:0] thresh_24v,
  input wire logic diff_mode,
  input wire logic [31:0] input_summary_word,
  input wire logic limit_pos,
  input wire logic home_switch,
  input wire logic interlock_fault,
  input wire logic route_active
);
  // ==========================================================
  // helpers
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_done;
  assign wr_done = psel && penable && pready && pwrite;

  // ==========================================================
  // assertions
  AST_RO_WRITE: assert property (psel && penable && pwrite &&
    (paddr == 12'h010 || paddr == 12'h020) |-> pslverr)
    else $error("write to read-only place not refused");
  AST_THRESH: assert property (wr_done && paddr == 12'h014 |=>
    thresh_24v == $past(pwdata[5:0]))
    else $error("threshold select not taken");
  AST_DIFF: assert property (wr_done && paddr == 12'h018 |=>
    diff_mode == $past(pwdata[0]))
    else $error("differential select not taken");
  AST_READ_LAT: assert property (psel && penable && !pwrite &&
    !$past(penable) && paddr <= 12'h020 |-> !pready ##1 !pready ##1 pready)
    else $error("read answer not in third access cycle");
  AST_ROUTE_ON: assert property (wr_done && paddr == 12'h01C &&
    pwdata[0] |-> ##[1:100] route_active)
    else $error("routing did not come up");
  AST_ROUTE_OFF: assert property (wr_done && paddr == 12'h01C &&
    !pwdata[0] |-> ##[1:4] !route_active)
    else $error("routing did not go down");
  AST_INTERLOCK: assert property (interlock_fault &&
    $stable(input_summary_word) |-> !input_summary_word[3])
    else $error("interlock fault with summary bit 3 high");
  AST_CLKDIR: assert property (clkdir_mode [*3] |->
    !limit_pos && !home_switch)
    else $error("limit or home active in clock-direction mode");
  AST_LEVEL_UPPER: assert property (!route_active [*6] |->
    input_summary_word[31:22] == 10'h000)
    else $error("summary level bits above input 6 set");
endmodule

bind dicr_input_router dicr_input_router_props #(
  .SAMPLE_CYCLES(SAMPLE_CYCLES)
) i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .clkdir_mode(clkdir_mode), .thresh_24v(thresh_24v),
  .diff_mode(diff_mode), .input_summary_word(input_summary_word),
  .limit_pos(limit_pos), .home_switch(home_switch),
  .interlock_fault(interlock_fault), .route_active(route_active)
);

// ### verification/dicr_pin_model.sv
// pin model: switches, sensors and encoder lines outside the block
// assumes: bench changes wanted levels just after a rising pclk edge
`timescale 1ns/1ps
module dicr_pin_model (
  // wanted levels
  input wire logic [5:0] want_pin,
  input wire logic [3:0] want_aux,
  // driven lines
  output logic [5:0] in_pin,
  output logic [3:0] aux
);
  // lines follow the wanted levels at once, with no delay or filtering
  assign in_pin = want_pin;
  assign aux = want_aux;
endmodule

// ### verification/tb_digital_input_conditioning_router.sv
// testbench: apb master, pin model and behavioural summary model
// assumes: short sample tick of SC cycles, 40 MHz pclk
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module tb_digital_input_conditioning_router;
  localparam int unsigned SC = 40;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, e;
  logic [5:0] in_pin, want_pin, thresh_24v, inv, fen, fval;
  logic [3:0] aux, want_aux, sfe;
  logic clkdir_mode, diff_mode, limit_neg, limit_pos, home_switch;
  logic interlock_fault, route_active;
  logic [31:0] summary;
  int bad_count, checked, cyc;
  logic [11:0] offs [6] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h014,
    12'h018};
  logic [31:0] msk [6] = '{32'h0000_000F, 32'h0000_003F, 32'h0000_003F,
    32'h0000_003F, 32'h0000_003F, 32'h0000_0001};
  logic [7:0] codes [16] = '{8'h00, 8'h01, 8'h03, 8'h06, 8'h0A, 8'h10,
    8'h44, 8'h45, 8'h46, 8'h47, 8'h80, 8'h81, 8'h86, 8'h90, 8'hC4, 8'hC7};

  // ==========================================================
  // design, pin model and clock
  dicr_input_router #(.SAMPLE_CYCLES(SC)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_pin(in_pin), .enc_a(aux[0]),
    .enc_b(aux[1]), .enc_index(aux[2]), .usb_power(aux[3]),
    .clkdir_mode(clkdir_mode), .thresh_24v(thresh_24v),
    .diff_mode(diff_mode), .input_summary_word(summary),
    .limit_neg(limit_neg), .limit_pos(limit_pos),
    .home_switch(home_switch), .interlock_fault(interlock_fault),
    .route_active(route_active));
  dicr_pin_model i_pins (.want_pin(want_pin), .want_aux(want_aux),
    .in_pin(in_pin), .aux(aux));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // cycle ceiling against hangs
  always @(posedge pclk) begin
    cyc++;
    if (cyc >= 30000) begin
      bad_count++;
      results();
    end
  end

  // ==========================================================
  // bus task and models
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    if (n >= 200) bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cfg();
    apb(1'b1, 12'h000, {28'h0, sfe});
    apb(1'b1, 12'h004, {26'h0, inv});
    apb(1'b1, 12'h008, {26'h0, fen});
    apb(1'b1, 12'h00C, {26'h0, fval});
  endtask

  // normal-mode summary: sample, force, then polarity
  function automatic logic [31:0] exp_norm();
    logic [31:0] s;
    logic [5:0] l;
    l = ((fen & fval) | (~fen & want_pin)) ^ inv;
    s = 32'h0000_0000;
    s[21:16] = l;
    s[2:0] = l[2:0] & sfe[2:0];
    return s;
  endfunction

  // routed source value for one code
  function automatic logic src(input logic [7:0] c);
    logic v;
    v = 1'b0;
    if (c[6:0] >= 7'h01 && c[6:0] <= 7'h06) v = want_pin[c[6:0] - 7'h01];
    if (c[6:0] >= 7'h44 && c[6:0] <= 7'h47) v = want_aux[c[6:0] - 7'h44];
    return v ^ c[7];
  endfunction

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, clkdir_mode} = '0;
    {want_pin, want_aux, sfe, inv, fen, fval} = '0;
    {bad_count, checked, cyc} = '0;
    void'($urandom(77848));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
    end
    for (int i = 0; i < 6; i++) begin
      e = $urandom;
      apb(1'b1, offs[i], e);
      apb(1'b0, offs[i], 32'h0000_0000);
      `CHK(rd, e & msk[i])
    end
    apb(1'b1, 12'h018, 32'h0000_0000);
    $display("test registers done");
    for (int t = 0; t < 8; t++) begin
      {sfe, inv, fen, fval} = 22'($urandom);
      cfg();
      want_pin <= 6'($urandom);
      repeat (3 * SC) @(posedge pclk);
      apb(1'b0, 12'h010, 32'h0000_0000);
      `CHK(rd, {26'h0, want_pin})
      apb(1'b0, 12'h020, 32'h0000_0000);
      e = exp_norm();
      `CHK(rd, e)
      `CHK({home_switch, limit_pos, limit_neg}, e[2:0])
    end
    $display("test normal done");
    want_pin <= want_pin ^ 6'h10;
    clkdir_mode <= 1'b1;
    @(posedge pclk);
    want_pin <= want_pin ^ 6'h10;
    repeat (8) @(posedge pclk);
    clkdir_mode <= 1'b0;
    repeat (3 * SC) @(posedge pclk);
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK(rd, {26'h0, want_pin})
    {sfe, inv, fen} = '0;
    cfg();
    apb(1'b1, 12'h018, 32'h0000_0001);
    want_pin <= 6'b110110;
    repeat (3 * SC) @(posedge pclk);
    apb(1'b0, 12'h020, 32'h0000_0000);
    `CHK(rd, 32'h0001_0000)
    apb(1'b1, 12'h018, 32'h0000_0000);
    $display("test glitch and differential done");
    inv = 6'($urandom);
    sfe = 4'($urandom) & 4'h7;
    cfg();
    want_pin <= 6'($urandom);
    repeat (3 * SC) @(posedge pclk);
    e = exp_norm();
    apb(1'b1, 12'h01C, 32'h0000_0001);
    repeat (5 * SC) @(posedge pclk);
    `CHK(route_active, 1'b1)
    apb(1'b0, 12'h020, 32'h0000_0000);
    `CHK(rd, e)
    apb(1'b0, 12'h0C0, 32'h0000_0000);
    `CHK(rd, {24'h0, inv[0], 7'h01})
    apb(1'b1, 12'h004, {26'h0, ~inv});
    repeat (3 * SC) @(posedge pclk);
    apb(1'b0, 12'h020, 32'h0000_0000);
    `CHK(rd, e)
    for (int k = 0; k < 32; k++) apb(1'b1, 12'h080 + 12'(4 * k), codes[k % 16]);
    apb(1'b0, 12'h084, 32'h0000_0000);
    `CHK(rd, {24'h0, codes[1]})
    for (int r = 0; r < 3; r++) begin
      want_pin <= 6'($urandom);
      want_aux <= 4'($urandom);
      repeat (5 * SC) @(posedge pclk);
      for (int b = 0; b < 32; b++) e[b] = src(codes[b % 16]);
      apb(1'b0, 12'h020, 32'h0000_0000);
      `CHK(rd, e)
    end
    $display("test routing done");
    apb(1'b1, 12'h000, 32'h0000_0008);
    apb(1'b1, 12'h08C, 32'h0000_0001);
    for (int v = 0; v < 2; v++) begin
      want_pin <= 6'(v);
      repeat (5 * SC) @(posedge pclk);
      `CHK(interlock_fault, 1'(v == 0))
    end
    apb(1'b1, 12'h01C, 32'h0000_0000);
    repeat (3 * SC) @(posedge pclk);
    `CHK(route_active, 1'b0)
    $display("test interlock done");
    apb(1'b0, 12'h040, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    apb(1'b1, 12'h020, 32'h0000_0005);
    `CHK(err, 1'b1)
    apb(1'b1, 12'h010, 32'h0000_0005);
    `CHK(err, 1'b1)
    $display("test refusals done");
    results();
  end
endmodule
